// [logic/timer16_defs.vh]
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH
`define WS_NORMAL      4'h0
`define WS_CTC_CMPA    4'h4
`define WS_FPWM_8      4'h5
`define WS_FPWM_9      4'h6
`define WS_FPWM_10     4'h7
`define WS_CTC_CAPT    4'hc
`define WS_FPWM_CAPT   4'he
`define WS_FPWM_CMPA   4'hf
`define TOP_FIX_8      16'h00ff
`define TOP_FIX_9      16'h01ff
`define TOP_FIX_10     16'h03ff
`define CNT_MAX        16'hffff
`define CNT_BOTTOM     16'h0000
`define COA_NONE       2'h0
`define COA_TOGGLE     2'h1
`define COA_CLEAR      2'h2
`define COA_SET        2'h3
`define LATCH_RESET    1'b0
`define CMP_RESET      16'h0000
`endif

// [logic/compare_output_unit.v]
`timescale 1ns/1ps
`include "timer16_defs.vh"
module compare_output_unit
(
    input  wire       clk_sys,               // System clock.
    input  wire       rst_b,                 // Asynchronous reset, active low.
    input  wire       clk_en,                // Clock enable.
    input  wire       timer_tick,            // Prescaled timer clock enable.
    input  wire       pwm_mode,              // Fast PWM mode active.
    input  wire       match,                 // Compare match this tick.
    input  wire       at_top,                // Counter clears on this tick (PWM).
    input  wire       force_strobe,          // Force compare strobe.
    input  wire [1:0] action,                // Compare output action.
    input  wire       port_value,            // Normal port output value.
    input  wire       output_pin_direction,  // Port direction bit.
    output reg        latch,                 // Compare output latch.
    output reg        pin_out,               // Pin output value.
    output reg        pin_oe                 // Pin output enable.
);
    reg next_latch;

    always @*
    begin
        next_latch = latch;
        if (!pwm_mode)
        begin
            if ((timer_tick && match) || force_strobe) // see RULE6
            begin
                case (action)                          // see RULE5
                    `COA_TOGGLE: next_latch = ~latch;
                    `COA_CLEAR:  next_latch = 1'b0;
                    `COA_SET:    next_latch = 1'b1;
                    default:     next_latch = latch;
                endcase
            end
        end
        else if (timer_tick)
        begin
            if (at_top)
            begin
                if (action == `COA_CLEAR)              // see RULE17
                    next_latch = 1'b1;
                else if (action == `COA_SET)           // see RULE24
                    next_latch = 1'b0;
            end
            else if (match)
            begin
                if (action == `COA_CLEAR)              // see RULE17
                    next_latch = 1'b0;
                else if (action == `COA_SET)
                    next_latch = 1'b1;
            end
        end
    end

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latch   <= `LATCH_RESET;                   // see RULE3
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end
        else if (clk_en)
        begin
            latch   <= next_latch;
            pin_out <= (action != `COA_NONE) ? next_latch : port_value; // see RULE1
            pin_oe  <= output_pin_direction;                            // see RULE2
        end
    end
endmodule // compare_output_unit

// [logic/timer16_waveform_modes.v]
// How it works
// RULE1 - Nonzero output action makes the pin show the latch instead of port value.
// RULE2 - Pin direction always follows the port direction bit.
// RULE3 - Reset clears the compare output latch to zero.
// RULE4 - Output action never touches input capture.
// RULE5 - Action zero leaves the latch unchanged on a match.
// RULE6 - New action acts at next match; force strobe acts now in non-PWM.
// RULE7 - Only waveform select picks counting; action only picks output behaviour.
// RULE8 - Mode 0 counts up, wraps 0xFFFF to 0, accepts writes anytime.
// RULE9 - Normal mode sets overflow when counter becomes zero; hardware only sets.
// RULE10 - Clear-on-match clears at compare A (4) or capture register (12).
// RULE11 - Top is unbuffered; a top below count runs counter through wrap.
// RULE12 - Clear-on-match sets compare A or capture flag at top.
// RULE13 - Clear-on-match with action 1 toggles the latch on each match.
// RULE14 - Clear-on-match sets overflow when passing max to zero.
// RULE15 - Fast PWM counts zero to top; top fixed, capture, or compare A.
// RULE16 - Fixed tops 0xFF, 0x1FF, 0x3FF; clear on tick after equal top.
// RULE17 - Non-inverting clears on match, sets at bottom; inverting opposite.
// RULE18 - Software keeps variable top at least 3.
// RULE19 - Fast PWM sets overflow at top plus compare A or capture flag.
// RULE20 - Each unit flags when counter equals its compare value.
// RULE21 - Fixed top masks compare bits above resolution on write.
// RULE22 - Software keeps top at least every compare value.
// RULE23 - Fast PWM buffers compare A writes, loads them at top.
// RULE24 - Fast PWM action 2 non-inverted, 3 inverted.
// RULE25 - Counter, flags and compare logic advance only on timer ticks.
`timescale 1ns/1ps
`include "timer16_defs.vh"
module timer16_waveform_modes
#(
    parameter WIDTH = 16                         // Counter width.
)
(
    input  wire             clk_sys,             // System clock, 10 MHz.
    input  wire             rst_b,               // Asynchronous reset, active low.
    input  wire             clk_en,              // Freezes all state when low.
    input  wire             timer_tick,          // Prescaled timer clock enable.
    input  wire [3:0]       waveform_select,     // Counting mode.
    input  wire [1:0]       compare_a_output_action, // Unit A action.
    input  wire [1:0]       compare_b_output_action, // Unit B action.
    input  wire             counter_write,       // Software counter write strobe.
    input  wire [WIDTH-1:0] counter_write_data,  // Value written to counter.
    input  wire             compare_a_write,     // Compare A write strobe.
    input  wire             compare_b_write,     // Compare B write strobe.
    input  wire [WIDTH-1:0] compare_write_data,  // Value written to compare.
    input  wire [WIDTH-1:0] capture_register_value, // Capture register.
    input  wire             force_compare_a,     // Force strobe unit A.
    input  wire             force_compare_b,     // Force strobe unit B.
    input  wire             overflow_flag_clear, // Clear overflow flag.
    input  wire             compare_a_flag_clear, // Clear compare A flag.
    input  wire             compare_b_flag_clear, // Clear compare B flag.
    input  wire             capture_flag_clear,  // Clear capture flag.
    input  wire             port_a_value,        // Port value for pin A.
    input  wire             port_b_value,        // Port value for pin B.
    input  wire             dir_a_pin,           // Direction bit pin A, asynchronous.
    input  wire             dir_b_pin,           // Direction bit pin B, asynchronous.
    output reg  [WIDTH-1:0] counter_value,       // Counter.
    output reg  [WIDTH-1:0] compare_a_value,     // Active compare A.
    output reg  [WIDTH-1:0] compare_b_value,     // Active compare B.
    output reg              overflow_flag,       // Overflow flag.
    output reg              compare_a_flag,      // Compare A flag.
    output reg              compare_b_flag,      // Compare B flag.
    output reg              capture_flag,        // Capture top flag.
    output wire             compare_a_output_latch, // Latch A.
    output wire             compare_b_output_latch, // Latch B.
    output wire             pin_a_out,           // Pin A output value.
    output wire             pin_a_oe,            // Pin A output enable.
    output wire             pin_b_out,           // Pin B output value.
    output wire             pin_b_oe             // Pin B output enable.
);
    reg  [WIDTH-1:0] compare_a_buffer;
    reg              block_match;
    reg  [1:0]       dir_a_sync;
    reg  [1:0]       dir_b_sync;
    reg  [WIDTH-1:0] next_counter;
    wire             is_pwm;
    wire             is_ctc;
    wire             fixed_top;
    wire [WIDTH-1:0] top_value;
    wire [WIDTH-1:0] top_mask;
    wire             at_top;
    wire             match_a;
    wire             match_b;

    // Fixed-top modes define an active resolution mask.
    function [WIDTH-1:0] resolution_mask;
        input [3:0] ws;
        begin
            case (ws)
                `WS_FPWM_8:  resolution_mask = `TOP_FIX_8;
                `WS_FPWM_9:  resolution_mask = `TOP_FIX_9;
                `WS_FPWM_10: resolution_mask = `TOP_FIX_10;
                default:     resolution_mask = `CNT_MAX;
            endcase
        end
    endfunction

    assign is_pwm = (waveform_select == `WS_FPWM_8) || (waveform_select == `WS_FPWM_9) ||
                    (waveform_select == `WS_FPWM_10) || (waveform_select == `WS_FPWM_CAPT) ||
                    (waveform_select == `WS_FPWM_CMPA); // see RULE15
    assign is_ctc = (waveform_select == `WS_CTC_CMPA) || (waveform_select == `WS_CTC_CAPT);
    assign top_mask  = resolution_mask(waveform_select);
    assign fixed_top = (top_mask != `CNT_MAX);
    // Capture register and CLEAR_ON_MATCH_MODE compare A act unbuffered as top.
    assign top_value = ((waveform_select == `WS_CTC_CAPT) ||
                        (waveform_select == `WS_FPWM_CAPT)) ? capture_register_value : // see RULE11
                       fixed_top ? top_mask : compare_a_value;                         // see RULE16
    assign at_top  = (is_pwm || is_ctc) && (counter_value == top_value) && !block_match;
    assign match_a = (counter_value == compare_a_value) && !block_match; // see RULE20
    assign match_b = (counter_value == compare_b_value) && !block_match;

    // Counting depends only on waveform select; the actions never enter here.
    always @*
    begin
        next_counter = counter_value + 1'b1;                // see RULE7
        if (at_top)
            next_counter = `CNT_BOTTOM;                     // see RULE10
    end

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dir_a_sync <= 2'h0;
            dir_b_sync <= 2'h0;
        end
        else if (clk_en)
        begin
            dir_a_sync <= {dir_a_sync[0], dir_a_pin};
            dir_b_sync <= {dir_b_sync[0], dir_b_pin};
        end
    end

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            counter_value    <= `CMP_RESET;
            compare_a_value  <= `CMP_RESET;
            compare_b_value  <= `CMP_RESET;
            compare_a_buffer <= `CMP_RESET;
            block_match      <= 1'b0;
            overflow_flag    <= 1'b0;
            compare_a_flag   <= 1'b0;
            compare_b_flag   <= 1'b0;
            capture_flag     <= 1'b0;
        end
        else if (clk_en)
        begin
            // A counter write blocks matches on the next timer tick.
            if (counter_write)
                block_match <= 1'b1;
            else if (timer_tick)
                block_match <= 1'b0;
            if (counter_write)
                counter_value <= counter_write_data;        // see RULE8
            else if (timer_tick)
                counter_value <= next_counter;              // see RULE25

            if (compare_a_write)
            begin
                compare_a_buffer <= compare_write_data & top_mask; // see RULE21
                if (!is_pwm)
                    compare_a_value <= compare_write_data & top_mask;
            end
            if (compare_b_write)
                compare_b_value <= compare_write_data & top_mask;
            if (is_pwm && timer_tick && at_top && !compare_a_write)
                compare_a_value <= compare_a_buffer;        // see RULE23

            // Set wins over clear for every flag; capture logic is untouched.
            if (timer_tick && ((is_pwm && at_top) ||
                (!is_pwm && (counter_value == `CNT_MAX))))  // see RULE9
                overflow_flag <= 1'b1;                      // see RULE14
            else if (overflow_flag_clear)
                overflow_flag <= 1'b0;
            if (timer_tick && (match_a || (at_top &&
                ((waveform_select == `WS_CTC_CMPA) || (waveform_select == `WS_FPWM_CMPA)))))
                compare_a_flag <= 1'b1;                     // see RULE12
            else if (compare_a_flag_clear)
                compare_a_flag <= 1'b0;
            if (timer_tick && match_b)
                compare_b_flag <= 1'b1;
            else if (compare_b_flag_clear)
                compare_b_flag <= 1'b0;
            if (timer_tick && at_top && ((waveform_select == `WS_CTC_CAPT) ||
                (waveform_select == `WS_FPWM_CAPT)))        // see RULE19
                capture_flag <= 1'b1;                       // see RULE4
            else if (capture_flag_clear)
                capture_flag <= 1'b0;
        end
    end

    // Unit A toggles on each match with action 1 in clear-on-match.
    compare_output_unit unit_a
    (
        .clk_sys              (clk_sys),
        .rst_b                (rst_b),
        .clk_en               (clk_en),
        .timer_tick           (timer_tick),
        .pwm_mode             (is_pwm),
        .match                (match_a),                    // see RULE13
        .at_top               (at_top),
        .force_strobe         (force_compare_a),
        .action               (compare_a_output_action),
        .port_value           (port_a_value),
        .output_pin_direction (dir_a_sync[1]),
        .latch                (compare_a_output_latch),
        .pin_out              (pin_a_out),
        .pin_oe               (pin_a_oe)
    );

    compare_output_unit unit_b
    (
        .clk_sys              (clk_sys),
        .rst_b                (rst_b),
        .clk_en               (clk_en),
        .timer_tick           (timer_tick),
        .pwm_mode             (is_pwm),
        .match                (match_b),
        .at_top               (at_top),
        .force_strobe         (force_compare_b),
        .action               (compare_b_output_action),
        .port_value           (port_b_value),
        .output_pin_direction (dir_b_sync[1]),
        .latch                (compare_b_output_latch),
        .pin_out              (pin_b_out),
        .pin_oe               (pin_b_oe)
    );
endmodule // timer16_waveform_modes

// [tb/port_pin_model.sv]
`timescale 1ns/1ps
module port_pin_model
(
    input  wire logic pin_out,    // Value offered by the block.
    input  wire logic pin_oe,     // Block drives the pin.
    output logic      pin_level   // Level seen on the wire.
);
    // The pin carries a pull-up, so a released pin reads high.
    assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule // port_pin_model

// [tb/timer16_waveform_modes_properties.sv]
`timescale 1ns/1ps
module timer16_checker
(
    input wire        clk_sys,                  // System clock.
    input wire        rst_b,                    // Reset, active low.
    input wire        clk_en,                   // Clock enable.
    input wire        timer_tick,               // Timer tick.
    input wire [3:0]  waveform_select,          // Counting mode.
    input wire [1:0]  compare_a_output_action,  // Unit A action.
    input wire        counter_write,            // Counter write.
    input wire        compare_a_write,          // Compare A write.
    input wire        force_compare_a,          // Force A.
    input wire        port_a_value,             // Port value A.
    input wire        dir_a_pin,                // Direction A.
    input wire [15:0] counter_value,            // Counter.
    input wire [15:0] compare_a_value,          // Active compare A.
    input wire [15:0] compare_b_value,          // Active compare B.
    input wire        overflow_flag,            // Overflow flag.
    input wire        compare_a_flag,           // Compare A flag.
    input wire        compare_b_flag,           // Compare B flag.
    input wire        compare_a_output_latch,   // Latch A.
    input wire        pin_a_out,                // Pin A value.
    input wire        pin_a_oe                  // Pin A enable.
);
    logic blocked;
    logic go;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // A counter write masks the matches of the next timer tick.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            blocked <= 1'b0;
        else if (clk_en && counter_write)
            blocked <= 1'b1;
        else if (clk_en && timer_tick)
            blocked <= 1'b0;
    end
    assign go = clk_en && timer_tick && !counter_write && !blocked;
    reset_clear_a: assert property ($rose(rst_b) |-> !compare_a_output_latch)
        else $error("latch not cleared by reset");
    normal_wrap_a: assert property (clk_en && timer_tick && !counter_write &&
        waveform_select == 4'h0 && counter_value == 16'hffff |=> counter_value == 16'h0000
        && overflow_flag) else $error("normal wrap wrong");
    ctc_top_a: assert property (go && waveform_select == 4'h4 &&
        counter_value == compare_a_value |=> counter_value == 16'h0000 && compare_a_flag)
        else $error("clear on match wrong");
    ctc_toggle_a: assert property (go && waveform_select == 4'h4 &&
        compare_a_output_action == 2'h1 && !force_compare_a && counter_value == compare_a_value
        |=> compare_a_output_latch != $past(compare_a_output_latch)) else $error("no toggle");
    pwm8_top_a: assert property (go && waveform_select == 4'h5 &&
        counter_value == 16'h00ff |=> counter_value == 16'h0000 && overflow_flag)
        else $error("fixed top wrong");
    pwm15_top_a: assert property (go && waveform_select == 4'hf && !compare_a_write &&
        counter_value == compare_a_value |=> counter_value == 16'h0000 && overflow_flag
        && compare_a_flag) else $error("variable top wrong");
    no_action_a: assert property (compare_a_output_action == 2'h0 && !force_compare_a
        |=> $stable(compare_a_output_latch)) else $error("latch moved with no action");
    pin_source_a: assert property (clk_en |=> pin_a_out ==
        ($past(compare_a_output_action) != 2'h0 ? compare_a_output_latch : $past(port_a_value)))
        else $error("pin source wrong");
    dir_follow_a: assert property ((dir_a_pin && clk_en) [*4] |-> pin_a_oe)
        else $error("pin enable not following direction");
    flag_b_a: assert property (go && waveform_select == 4'h4 &&
        counter_value == compare_b_value |=> compare_b_flag) else $error("compare B flag missing");
endmodule // timer16_checker

// [tb/timer16_waveform_modes_tb.sv]
`timescale 1ns/1ps
`include "timer16_defs.vh"
module timer16_waveform_modes_tb;
    logic        clk_sys, rst_b, clk_en, timer_tick, counter_write, compare_a_write;
    logic        compare_b_write, force_compare_a, force_compare_b, overflow_flag_clear;
    logic        compare_a_flag_clear, compare_b_flag_clear, capture_flag_clear, port_a_value;
    logic        port_b_value, dir_a_pin, dir_b_pin, pin_level;
    logic [3:0]  waveform_select;
    logic [1:0]  compare_a_output_action, compare_b_output_action;
    logic [15:0] counter_write_data, compare_write_data, capture_register_value;
    logic [15:0] counter_value, compare_a_value, compare_b_value;
    logic        overflow_flag, compare_a_flag, compare_b_flag, capture_flag;
    logic        compare_a_output_latch, compare_b_output_latch, pin_a_out, pin_a_oe;
    logic        pin_b_out, pin_b_oe;
    int          failures = 0;
    int          tests_run = 0;
    timer16_waveform_modes dut (.*);
    port_pin_model pin_a (.pin_out(pin_a_out), .pin_oe(pin_a_oe), .pin_level(pin_level));
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Ticks n timer clocks and waits for the results to settle.
    task automatic tick(input int n);
        @(posedge clk_sys) timer_tick <= 1'b1;
        repeat (n) @(posedge clk_sys);
        timer_tick <= 1'b0;
        #1;
    endtask
    // One-cycle strobe: 0 counter, 1 compare A, 2 compare B, 3 force A, else flag clears.
    task automatic wr(input int which, input logic [15:0] v);
        @(posedge clk_sys);
        counter_write_data <= v;
        compare_write_data <= v;
        case (which)
            0: counter_write <= 1'b1;
            1: compare_a_write <= 1'b1;
            2: compare_b_write <= 1'b1;
            3: force_compare_a <= 1'b1;
            default: {overflow_flag_clear, compare_a_flag_clear, compare_b_flag_clear,
                      capture_flag_clear} <= 4'hf;
        endcase
        @(posedge clk_sys);
        {counter_write, compare_a_write, compare_b_write, force_compare_a} <= 4'h0;
        {overflow_flag_clear, compare_a_flag_clear, compare_b_flag_clear, capture_flag_clear} <= 4'h0;
        #1;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        report_and_stop;
    end
    initial
    begin
        {rst_b, clk_en, timer_tick, counter_write, compare_a_write, compare_b_write} = '0;
        {force_compare_a, force_compare_b, overflow_flag_clear, compare_a_flag_clear} = '0;
        {compare_b_flag_clear, capture_flag_clear, port_a_value, port_b_value} = '0;
        {dir_a_pin, dir_b_pin, waveform_select, compare_a_output_action} = '0;
        {compare_b_output_action, counter_write_data, compare_write_data} = '0;
        capture_register_value = 16'h0000;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        clk_en <= 1'b1;
        #1;
        check("latch_a", compare_a_output_latch, 16'h0000);
        wr(0, 16'hffff);
        tick(1);
        check("counter", counter_value, 16'h0000);
        check("overflow", overflow_flag, 16'h0001);
        @(posedge clk_sys) clk_en <= 1'b0;
        tick(2);
        check("frozen", counter_value, 16'h0000);
        @(posedge clk_sys) clk_en <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_sys) compare_a_output_action <= 2'(10'h1f8 >> (8 - 2 * i));
            wr(3, 16'h0000);
            check("forced_latch", compare_a_output_latch, 16'((5'h1c >> (4 - i)) & 1));
        end
        check("forced_flag", compare_a_flag, 16'h0000);
        @(posedge clk_sys) {port_a_value, port_b_value, dir_a_pin, dir_b_pin} <= 4'hf;
        repeat (4) @(posedge clk_sys);
        #1;
        check("port_level", pin_level, 16'h0001);
        check("port_b", pin_b_out, 16'h0001);
        check("drive_oe", {pin_a_oe, pin_b_oe}, 16'h0003);
        @(posedge clk_sys) compare_a_output_action <= `COA_CLEAR;
        wr(3, 16'h0000);
        check("latch_level", pin_level, 16'h0000);
        @(posedge clk_sys) dir_a_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        check("input_oe", pin_a_oe, 16'h0000);
        check("input_level", pin_level, 16'h0001);
        @(posedge clk_sys) waveform_select <= `WS_CTC_CMPA;
        compare_a_output_action <= `COA_TOGGLE;
        compare_b_output_action <= `COA_SET;
        wr(1, 16'h0003);
        wr(2, 16'h0002);
        wr(4, 16'h0000);
        wr(0, 16'h0000);
        tick(4);
        check("ctc_counter", counter_value, 16'h0000);
        check("ctc_flag_a", compare_a_flag, 16'h0001);
        check("ctc_flag_b", compare_b_flag, 16'h0001);
        check("ctc_toggle", compare_a_output_latch, 16'h0001);
        check("latch_b", compare_b_output_latch, 16'h0001);
        check("ctc_no_ovf", overflow_flag, 16'h0000);
        @(posedge clk_sys) waveform_select <= `WS_CTC_CAPT;
        capture_register_value <= 16'h0005;
        wr(4, 16'h0000);
        wr(0, 16'hfffe);
        tick(2);
        check("wrap_ovf", overflow_flag, 16'h0001);
        check("wrap_no_top", capture_flag, 16'h0000);
        tick(6);
        check("capt_counter", counter_value, 16'h0000);
        check("capt_flag", capture_flag, 16'h0001);
        @(posedge clk_sys) waveform_select <= `WS_FPWM_8;
        compare_a_output_action <= `COA_CLEAR;
        wr(1, 16'h1234);
        check("buffered", compare_a_value, 16'h0003);
        wr(4, 16'h0000);
        wr(0, 16'h00fe);
        tick(2);
        check("pwm_counter", counter_value, 16'h0000);
        check("pwm_ovf", overflow_flag, 16'h0001);
        check("masked_load", compare_a_value, 16'h0034);
        check("bottom_set", compare_a_output_latch, 16'h0001);
        tick(16'h35);
        check("match_clear", compare_a_output_latch, 16'h0000);
        check("match_flag", compare_a_flag, 16'h0001);
        @(posedge clk_sys) waveform_select <= `WS_FPWM_CMPA;
        wr(1, 16'h0003);
        wr(4, 16'h0000);
        wr(0, 16'h0033);
        tick(2);
        check("top_counter", counter_value, 16'h0000);
        check("top_load", compare_a_value, 16'h0003);
        check("top_flags", {overflow_flag, compare_a_flag}, 16'h0003);
        check("top_latch", compare_a_output_latch, 16'h0001);
        @(posedge clk_sys) rst_b <= 1'b0;
        @(posedge clk_sys) rst_b <= 1'b1;
        #1;
        check("reset_latch", compare_a_output_latch, 16'h0000);
        report_and_stop;
    end
endmodule // timer16_waveform_modes_tb
bind timer16_waveform_modes timer16_checker chk (.*);
